// ### include/ctar_regs.vh
`ifndef CTAR_REGS_VH
`define CTAR_REGS_VH

// ****************************************
// control word field positions
// ****************************************
`define CTAR_MMU_EN_BIT 0
`define CTAR_DATA_CACHE_EN_BIT 2
`define CTAR_INSTR_CACHE_EN_BIT 12
`define CTAR_REPL_POLICY_BIT 14

// ****************************************
// route codes
// ****************************************
`define CTAR_ROUTE_NONE 2'h0
`define CTAR_ROUTE_AHB 2'h1
`define CTAR_ROUTE_CACHE 2'h2
`define CTAR_ROUTE_TIGHT 2'h3

// ****************************************
// reset values
// ****************************************
`define CTAR_ADDR_RST 32'h0000_0000
`define CTAR_DATA_RST 32'h0000_0000
`define CTAR_LFSR_SEED 8'h0001
`define CTAR_LFSR_TAPS 8'h00B8
`define CTAR_WAY_RST 8'h0000

`endif

// ### rtl/ctar_region_match.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// region hit detect
// ****************************************
// a region is an aligned power-of-two window; the low size_log2 bits
// of the base are ignored so a misaligned base cannot split the window
module ctar_region_match #(
  parameter AW = 32,
  parameter SW = 5
) (
  input wire [AW-1:0] addr,
  input wire [AW-1:0] base,
  input wire [SW-1:0] size_log2,
  input wire enable,
  output wire hit
);

  wire [AW-1:0] diff; // bits that differ from the base
  wire [AW-1:0] upper; // differing bits above the window size

  assign diff = addr ^ base;
  assign upper = diff >> size_log2;
  // disabled region never hits
  assign hit = enable & (upper == {AW{1'b0}});

endmodule

`default_nettype wire

// ### rtl/ctar_router.v
// Overview of operation
// - cache off: fetches go to external bus
// - instr cache on, mmu off: cacheable, unchecked, flat
// - instr cache, mmu on: entry cacheability, checked, translated
// - data cache off: data goes to external bus
// - data cache on, mmu off: noncacheable nonbufferable, flat
// - data cache, mmu on: entry cacheability, checked, translated
// - disabled cache is never looked up
// - region routing combines mmu and region enable
// - fetch region, no mmu/cache: tight or bus
// - fetch region, cache no mmu: tight or cache
// - fetch region, mmu and cache: tight, cache, or bus for noncacheable pages
// - data region, no mmu/cache: tight or bus
// - data region, cache no mmu: tight or bus
// - data region, mmu and cache: tight, cache, or bus for noncacheable pages
// - aborted reads may still reach tight memory
// - aborted writes never reach tight memory
// - policy bit: zero random, one round robin
// - control bits 0, 2, 12 enable functions
`timescale 1ns/1ps
`default_nettype none
`include "ctar_regs.vh"

module ctar_router #(
  parameter AW = 32,
  parameter DW = 32,
  parameter SW = 5,
  parameter WAYS_LOG2 = 2
) (
  input wire sys_clk,
  input wire rst_n,
  // control word as held by the coprocessor
  input wire [31:0] ctrl_word,
  // tightly coupled region settings
  input wire [AW-1:0] i_region_base,
  input wire [SW-1:0] i_region_size_log2,
  input wire i_region_enable,
  input wire [AW-1:0] d_region_base,
  input wire [SW-1:0] d_region_size_log2,
  input wire d_region_enable,
  // fetch request from the core
  input wire i_req,
  input wire [AW-1:0] i_virt_addr,
  input wire [AW-1:0] i_xlat_addr,
  input wire i_xlat_cacheable,
  input wire i_prot_fault,
  // data request from the core
  input wire d_req,
  input wire d_write,
  input wire [AW-1:0] d_virt_addr,
  input wire [DW-1:0] d_wdata,
  input wire [AW-1:0] d_xlat_addr,
  input wire d_xlat_cacheable,
  input wire d_xlat_bufferable,
  input wire d_prot_fault,
  input wire d_ext_abort,
  // line fill requests from the caches
  input wire i_fill_req,
  input wire d_fill_req,
  // fetch side results
  output reg [1:0] i_route_reg,
  output reg [AW-1:0] i_phys_addr_reg,
  output reg i_cacheable_reg,
  output reg i_prot_check_reg,
  output reg i_abort_reg,
  output reg i_cache_lookup_reg,
  output reg i_ahb_read_reg,
  output reg i_tight_read_reg,
  // data side results
  output reg [1:0] d_route_reg,
  output reg [AW-1:0] d_phys_addr_reg,
  output reg [DW-1:0] d_wdata_reg,
  output reg d_cacheable_reg,
  output reg d_bufferable_reg,
  output reg d_prot_check_reg,
  output reg d_abort_reg,
  output reg d_cache_lookup_reg,
  output reg d_ahb_read_reg,
  output reg d_ahb_write_reg,
  output reg d_tight_read_reg,
  output reg d_tight_write_reg,
  // victim way choice per cache
  output reg [WAYS_LOG2-1:0] i_victim_reg,
  output reg [WAYS_LOG2-1:0] d_victim_reg
);

  // ****************************************
  // control decode
  // ****************************************
  wire mmu_enable; // translation and checks on
  wire data_cache_enable; // data cache usable
  wire instr_cache_enable; // instruction cache usable
  wire replacement_policy_bit; // zero random, one round robin

  assign mmu_enable = ctrl_word[`CTAR_MMU_EN_BIT];
  assign data_cache_enable = ctrl_word[`CTAR_DATA_CACHE_EN_BIT];
  assign instr_cache_enable = ctrl_word[`CTAR_INSTR_CACHE_EN_BIT];
  assign replacement_policy_bit = ctrl_word[`CTAR_REPL_POLICY_BIT];

  // ****************************************
  // effective addresses
  // ****************************************
  // flat map when translation is off, else the translated address
  wire [AW-1:0] i_eff_addr; // fetch physical address
  wire [AW-1:0] d_eff_addr; // data physical address

  assign i_eff_addr = mmu_enable ? i_xlat_addr : i_virt_addr;
  assign d_eff_addr = mmu_enable ? d_xlat_addr : d_virt_addr;

  // ****************************************
  // region hits
  // ****************************************
  wire i_region_hit; // fetch lands in instruction region
  wire d_region_hit; // data lands in data region

  // matching on the physical address ties region enable to the mmu state
  ctar_region_match #(
    .AW(AW),
    .SW(SW)
  ) u_i_region (
    .addr(i_eff_addr),
    .base(i_region_base),
    .size_log2(i_region_size_log2),
    .enable(i_region_enable),
    .hit(i_region_hit)
  );

  ctar_region_match #(
    .AW(AW),
    .SW(SW)
  ) u_d_region (
    .addr(d_eff_addr),
    .base(d_region_base),
    .size_log2(d_region_size_log2),
    .enable(d_region_enable),
    .hit(d_region_hit)
  );

  // ****************************************
  // fetch routing
  // ****************************************
  reg [1:0] i_route_next; // chosen destination
  reg i_cacheable_next; // cacheability of the fetch
  reg i_check_next; // protection check applies
  reg i_abort_next; // fetch aborted

  // decision order: region, cache off, flat cacheable, entry driven
  always @* begin
    i_route_next = `CTAR_ROUTE_NONE;
    i_cacheable_next = 1'b0;
    i_check_next = mmu_enable;
    i_abort_next = 1'b0;
    if (i_req) begin
      i_abort_next = mmu_enable & i_prot_fault;
      if (i_region_hit) begin
        // region wins even when the cache would have hit
        i_route_next = `CTAR_ROUTE_TIGHT;
      end else if (!instr_cache_enable) begin
        i_route_next = `CTAR_ROUTE_AHB;
      end else if (!mmu_enable) begin
        i_route_next = `CTAR_ROUTE_CACHE;
        i_cacheable_next = 1'b1;
      end else begin
        i_cacheable_next = i_xlat_cacheable;
        // noncacheable pages bypass to the bus
        i_route_next = i_xlat_cacheable ? `CTAR_ROUTE_CACHE : `CTAR_ROUTE_AHB;
      end
    end
  end

  // ****************************************
  // data routing
  // ****************************************
  reg [1:0] d_route_next; // chosen destination
  reg d_cacheable_next; // cacheability of the access
  reg d_bufferable_next; // bufferability of the access
  reg d_check_next; // protection check applies
  reg d_abort_next; // access aborted

  // same order as fetch, but flat map with cache on stays uncached
  always @* begin
    d_route_next = `CTAR_ROUTE_NONE;
    d_cacheable_next = 1'b0;
    d_bufferable_next = 1'b0;
    d_check_next = mmu_enable;
    d_abort_next = 1'b0;
    if (d_req) begin
      d_abort_next = d_ext_abort | (mmu_enable & d_prot_fault);
      if (d_region_hit) begin
        d_route_next = `CTAR_ROUTE_TIGHT;
      end else if (!data_cache_enable) begin
        d_route_next = `CTAR_ROUTE_AHB;
      end else if (!mmu_enable) begin
        // noncacheable nonbufferable, straight to memory
        d_route_next = `CTAR_ROUTE_AHB;
      end else begin
        d_cacheable_next = d_xlat_cacheable;
        d_bufferable_next = d_xlat_bufferable;
        d_route_next = d_xlat_cacheable ? `CTAR_ROUTE_CACHE : `CTAR_ROUTE_AHB;
      end
    end
  end

  // ****************************************
  // strobe qualification
  // ****************************************
  wire i_to_tight; // fetch heads for the region
  wire i_to_cache; // fetch heads for the cache
  wire i_to_ahb; // fetch heads for the bus
  wire d_to_tight; // data heads for the region
  wire d_to_cache; // data heads for the cache
  wire d_to_ahb; // data heads for the bus

  assign i_to_tight = (i_route_next == `CTAR_ROUTE_TIGHT);
  assign i_to_cache = (i_route_next == `CTAR_ROUTE_CACHE);
  assign i_to_ahb = (i_route_next == `CTAR_ROUTE_AHB);
  assign d_to_tight = (d_route_next == `CTAR_ROUTE_TIGHT);
  assign d_to_cache = (d_route_next == `CTAR_ROUTE_CACHE);
  assign d_to_ahb = (d_route_next == `CTAR_ROUTE_AHB);

  // ****************************************
  // victim selection
  // ****************************************
  reg [7:0] lfsr_reg; // shared random source
  wire [7:0] lfsr_next; // galois step
  reg [WAYS_LOG2-1:0] i_turn_reg; // fetch round robin pointer
  reg [WAYS_LOG2-1:0] d_turn_reg; // data round robin pointer

  // one random source is shared; both caches drawing at once see the same
  // value, which costs a little spread but saves a second generator
  assign lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ `CTAR_LFSR_TAPS) : (lfsr_reg >> 1);

  // pointers advance only on a fill so each refill takes a fresh way
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      lfsr_reg <= `CTAR_LFSR_SEED;
      i_turn_reg <= {WAYS_LOG2{1'b0}};
      d_turn_reg <= {WAYS_LOG2{1'b0}};
      i_victim_reg <= {WAYS_LOG2{1'b0}};
      d_victim_reg <= {WAYS_LOG2{1'b0}};
    end else begin
      lfsr_reg <= lfsr_next;
      if (i_fill_req && instr_cache_enable) begin
        if (replacement_policy_bit) begin
          i_victim_reg <= i_turn_reg;
          i_turn_reg <= i_turn_reg + {{(WAYS_LOG2-1){1'b0}}, 1'b1};
        end else begin
          i_victim_reg <= lfsr_reg[WAYS_LOG2-1:0];
        end
      end
      if (d_fill_req && data_cache_enable) begin
        if (replacement_policy_bit) begin
          d_victim_reg <= d_turn_reg;
          d_turn_reg <= d_turn_reg + {{(WAYS_LOG2-1){1'b0}}, 1'b1};
        end else begin
          d_victim_reg <= lfsr_reg[WAYS_LOG2-1:0];
        end
      end
    end
  end

  // ****************************************
  // fetch output stage
  // ****************************************
  // one cycle from request to strobes; strobes repeat each cycle the request is held
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      i_route_reg <= `CTAR_ROUTE_NONE;
      i_phys_addr_reg <= `CTAR_ADDR_RST;
      i_cacheable_reg <= 1'b0;
      i_prot_check_reg <= 1'b0;
      i_abort_reg <= 1'b0;
      i_cache_lookup_reg <= 1'b0;
      i_ahb_read_reg <= 1'b0;
      i_tight_read_reg <= 1'b0;
    end else begin
      i_route_reg <= i_route_next;
      i_phys_addr_reg <= i_eff_addr;
      i_cacheable_reg <= i_cacheable_next;
      i_prot_check_reg <= i_check_next & i_req;
      i_abort_reg <= i_abort_next;
      // lookup only when the cache is on, so its lines stay untouched
      i_cache_lookup_reg <= i_to_cache & instr_cache_enable & ~i_abort_next;
      i_ahb_read_reg <= i_to_ahb & ~i_abort_next;
      // speculative: region read goes out even if aborted
      i_tight_read_reg <= i_to_tight;
    end
  end

  // ****************************************
  // data output stage
  // ****************************************
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      d_route_reg <= `CTAR_ROUTE_NONE;
      d_phys_addr_reg <= `CTAR_ADDR_RST;
      d_wdata_reg <= `CTAR_DATA_RST;
      d_cacheable_reg <= 1'b0;
      d_bufferable_reg <= 1'b0;
      d_prot_check_reg <= 1'b0;
      d_abort_reg <= 1'b0;
      d_cache_lookup_reg <= 1'b0;
      d_ahb_read_reg <= 1'b0;
      d_ahb_write_reg <= 1'b0;
      d_tight_read_reg <= 1'b0;
      d_tight_write_reg <= 1'b0;
    end else begin
      d_route_reg <= d_route_next;
      d_phys_addr_reg <= d_eff_addr;
      d_wdata_reg <= d_wdata;
      d_cacheable_reg <= d_cacheable_next;
      d_bufferable_reg <= d_bufferable_next;
      d_prot_check_reg <= d_check_next & d_req;
      d_abort_reg <= d_abort_next;
      d_cache_lookup_reg <= d_to_cache & data_cache_enable & ~d_abort_next;
      d_ahb_read_reg <= d_to_ahb & ~d_write & ~d_abort_next;
      d_ahb_write_reg <= d_to_ahb & d_write & ~d_abort_next;
      // reads may leak out speculatively, the memory must not mind
      d_tight_read_reg <= d_to_tight & ~d_write;
      // an aborted write must never reach the region
      d_tight_write_reg <= d_to_tight & d_write & ~d_abort_next;
    end
  end

endmodule

`default_nettype wire

// ### verif/ctar_tight_mem.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// tightly coupled memory partner
// ****************************************
module ctar_tight_mem (
  input wire logic sys_clk,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  output var logic [31:0] rdata,
  output var logic [31:0] wr_count
);
  logic [31:0] mem [0:15]; // small window, address wraps

  initial begin
    rdata = 32'h0000_0000;
    wr_count = 32'h0000_0000;
  end

  // writes land and are counted; reads never change state
  always @(posedge sys_clk) begin
    if (wr_stb) begin
      mem[addr[5:2]] <= wdata;
      wr_count <= wr_count + 32'h0000_0001;
    end
    // read outside a strobe shows inverted junk, not stale data
    rdata <= rd_stb ? mem[addr[5:2]] : ~rdata;
  end
endmodule

`default_nettype wire

// ### verif/ctar_router_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// port checker for the router
// ****************************************
module ctar_router_chk #(
  parameter WAYS_LOG2 = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [31:0] ctrl_word,
  input wire logic [31:0] i_region_base,
  input wire logic [4:0] i_region_size_log2,
  input wire logic i_region_enable,
  input wire logic [31:0] d_region_base,
  input wire logic [4:0] d_region_size_log2,
  input wire logic d_region_enable,
  input wire logic i_req,
  input wire logic [31:0] i_virt_addr,
  input wire logic d_req,
  input wire logic d_write,
  input wire logic [31:0] d_virt_addr,
  input wire logic d_ext_abort,
  input wire logic d_fill_req,
  input wire logic [1:0] i_route_reg,
  input wire logic [31:0] i_phys_addr_reg,
  input wire logic i_cacheable_reg,
  input wire logic i_prot_check_reg,
  input wire logic [1:0] d_route_reg,
  input wire logic d_cacheable_reg,
  input wire logic d_bufferable_reg,
  input wire logic d_abort_reg,
  input wire logic d_cache_lookup_reg,
  input wire logic d_tight_read_reg,
  input wire logic d_tight_write_reg,
  input wire logic [WAYS_LOG2-1:0] d_victim_reg
);
  wire i_hit; // flat address inside fetch region
  wire d_hit; // flat address inside data region
  wire turn_fill; // round robin fill on an enabled data cache

  // only valid while translation is off
  assign i_hit = i_region_enable && ((i_virt_addr ^ i_region_base) >> i_region_size_log2) == 0;
  assign d_hit = d_region_enable && ((d_virt_addr ^ d_region_base) >> d_region_size_log2) == 0;
  assign turn_fill = d_fill_req && ctrl_word[2] && ctrl_word[14];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_fetch_off_bus: assert property (i_req && !ctrl_word[12] && !i_region_enable |=>
    i_route_reg == 2'h1) else $error("fetch missed the bus with cache off");
  a_fetch_flat: assert property (i_req && ctrl_word[12] && !ctrl_word[0] && !i_hit |=>
    i_route_reg == 2'h2 && i_cacheable_reg && i_phys_addr_reg == $past(i_virt_addr))
    else $error("flat cached fetch wrong");
  a_check_follows_mmu: assert property (i_req |=>
    i_prot_check_reg == $past(ctrl_word[0])) else $error("fetch check flag wrong");
  a_data_off_bus: assert property (d_req && !ctrl_word[2] && !d_region_enable |=>
    d_route_reg == 2'h1) else $error("data missed the bus with cache off");
  a_dflat_uncached: assert property (d_req && ctrl_word[2] && !ctrl_word[0] |=>
    !d_cacheable_reg && !d_bufferable_reg) else $error("flat data marked cacheable");
  a_region_wins: assert property (i_req && !ctrl_word[0] && i_hit |=>
    i_route_reg == 2'h3) else $error("region hit not routed to tight side");
  a_aborted_read_kept: assert property (d_req && !d_write && !ctrl_word[0] && d_hit |=>
    d_route_reg == 2'h3 && d_tight_read_reg) else $error("tight read dropped");
  a_abort_no_write: assert property (d_req && d_write && d_ext_abort |=>
    d_abort_reg && !d_tight_write_reg) else $error("aborted write reached tight side");
  a_lookup_enabled: assert property (d_cache_lookup_reg |->
    $past(ctrl_word[2])) else $error("lookup in a disabled cache");
  a_turn_advance: assert property (turn_fill && $past(turn_fill) |=>
    d_victim_reg == $past(d_victim_reg) + 1'b1) else $error("round robin did not step");
endmodule

bind ctar_router ctar_router_chk #(.WAYS_LOG2(WAYS_LOG2)) ctar_router_chk_i (.*);

`default_nettype wire

// ### verif/ctar_router_bench.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// bench for the access router
// ****************************************
module ctar_router_bench;
  logic sys_clk = 1'b0; // 100 MHz
  logic rst_n; // low reset
  logic [31:0] ctrl_word, i_region_base, d_region_base, d_wdata; // control and bases
  logic [31:0] i_virt_addr, i_xlat_addr, d_virt_addr, d_xlat_addr; // addresses
  logic [4:0] i_region_size_log2, d_region_size_log2; // window sizes
  logic i_region_enable, d_region_enable, i_req, d_req, d_write; // request bits
  logic i_xlat_cacheable, i_prot_fault, d_xlat_cacheable, d_xlat_bufferable; // page bits
  logic d_prot_fault, d_ext_abort, i_fill_req, d_fill_req; // faults and fills
  wire [1:0] i_route_reg, d_route_reg, i_victim_reg, d_victim_reg; // routes, victims
  wire [31:0] i_phys_addr_reg, d_phys_addr_reg, d_wdata_reg, rdata, wr_count; // words
  wire i_cacheable_reg, i_prot_check_reg, i_abort_reg, i_cache_lookup_reg, i_ahb_read_reg;
  wire i_tight_read_reg, d_cacheable_reg, d_bufferable_reg, d_prot_check_reg, d_abort_reg;
  wire d_cache_lookup_reg, d_ahb_read_reg, d_ahb_write_reg, d_tight_read_reg, d_tight_write_reg;
  int n_fail = 0, cmp_count = 0, n_tw = 0, cyc = 0; // tallies
  logic [31:0] seed = 32'h0000_003E; // xorshift state
  logic [31:0] r, c, ib, db, iv, ix, dv, dx, e_ip, e_dp, e_fl, p_ip, p_dp, p_fl; // stimulus
  logic [31:0] wd, p_wd; // write data now and one cycle back
  logic [4:0] sz; // shared window size
  logic mmu, ih, dh, dab, ia, p_iq, p_dq; // expectation helpers
  logic [1:0] ir, dr, v; // expected routes and victim
  logic [7:0] lf; // model of the shared random source

  ctar_router ctar_router_i (.*);

  ctar_tight_mem ctar_tight_mem_i (.sys_clk(sys_clk), .wr_stb(d_tight_write_reg),
    .rd_stb(d_tight_read_reg), .addr(d_phys_addr_reg), .wdata(d_wdata_reg),
    .rdata(rdata), .wr_count(wr_count));

  always #5 sys_clk = ~sys_clk;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // aligned window match on the effective address
  function automatic logic hit(input logic en, input logic [31:0] b, a, input logic [4:0] s);
    return en && ((a ^ b) >> s) == 32'h0000_0000;
  endfunction

  // region first, then cache enable, then page attribute
  function automatic logic [1:0] route(input logic is_i, rq, m, cen, h, xc);
    if (!rq) return 2'h0;
    if (h) return 2'h3;
    if (!cen) return 2'h1;
    if (m) return xc ? 2'h2 : 2'h1;
    return is_i ? 2'h2 : 2'h1;
  endfunction

  task automatic chk(input logic [31:0] got, exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask

  task automatic complete_run();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // run needs about 2020 cycles; generous ceiling against a hang
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      complete_run();
    end
  end

  // galois step from seed 01 with taps b8, one step per cycle like the router
  always @(posedge sys_clk) begin
    lf <= !rst_n ? 8'h01 : (lf[0] ? ((lf >> 1) ^ 8'hB8) : (lf >> 1));
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    {ctrl_word, i_region_base, d_region_base, d_wdata, i_virt_addr, i_xlat_addr} = '0;
    {d_virt_addr, d_xlat_addr, i_region_size_log2, d_region_size_log2} = '0;
    {i_region_enable, d_region_enable, i_req, d_req, d_write, i_xlat_cacheable} = '0;
    {i_prot_fault, d_xlat_cacheable, d_xlat_bufferable, d_prot_fault, d_ext_abort} = '0;
    {i_fill_req, d_fill_req, p_ip, p_dp, p_fl, p_iq, p_dq, p_wd} = '0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int n = 0; n < 2000; n++) begin
      @(posedge sys_clk);
      r = xs();
      c = xs() & 32'h0000_5005; // only mmu, caches and policy bits
      ib = xs();
      db = xs();
      sz = 5'd8 + r[7:4];
      iv = r[10] ? ib ^ (xs() & 32'h0000_00FF) : xs();
      ix = r[11] ? ib ^ (xs() & 32'h0000_00FF) : xs();
      dv = r[12] ? db ^ (xs() & 32'h0000_00FF) : xs();
      dx = r[13] ? db ^ (xs() & 32'h0000_00FF) : xs();
      mmu = c[0];
      ih = hit(r[15], ib, mmu ? ix : iv, sz);
      dh = hit(r[14], db, mmu ? dx : dv, sz);
      dab = r[22] & ((r[27] & r[26]) | (mmu & r[18]));
      e_ip = r[25] ? (mmu ? ix : iv) : 32'h0000_0000;
      e_dp = r[22] ? (mmu ? dx : dv) : 32'h0000_0000;
      wd = xs();
      ir = route(1'b1, r[25], mmu, c[12], ih, r[24]);
      dr = route(1'b0, r[22], mmu, c[2], dh, r[20]);
      ia = r[25] & mmu & r[23];
      // aborts drop bus and cache strobes; tight reads still go out
      e_fl = {ir, dr, ia, dab, r[22] & r[21] & dh & !dab, r[22] & !r[21] & dh, r[25] & mmu,
        ir == 2'h2, ir == 2'h2 && !ia, ir == 2'h1 && !ia, ir == 2'h3, dr == 2'h2,
        r[22] & !dh & c[2] & mmu & r[19], r[22] & mmu, dr == 2'h2 && !dab,
        dr == 2'h1 && !r[21] && !dab, dr == 2'h1 && r[21] && !dab};
      n_tw += e_fl[12];
      ctrl_word <= c;
      {i_region_base, d_region_base, i_region_size_log2, d_region_size_log2} <= {ib, db, sz, sz};
      {i_virt_addr, i_xlat_addr, d_virt_addr, d_xlat_addr, d_wdata} <= {iv, ix, dv, dx, wd};
      {i_req, i_xlat_cacheable, i_prot_fault, d_req, d_write, d_xlat_cacheable} <= r[25:20];
      {d_xlat_bufferable, d_prot_fault, i_fill_req, d_fill_req} <= r[19:16];
      {i_region_enable, d_region_enable} <= r[15:14];
      d_ext_abort <= r[27] & r[26];
      #1;
      chk({i_route_reg, d_route_reg, i_abort_reg, d_abort_reg, d_tight_write_reg,
        d_tight_read_reg, i_prot_check_reg, i_cacheable_reg, i_cache_lookup_reg, i_ahb_read_reg,
        i_tight_read_reg, d_cacheable_reg, d_bufferable_reg, d_prot_check_reg, d_cache_lookup_reg,
        d_ahb_read_reg, d_ahb_write_reg}, p_fl, "route flags");
      chk(p_iq ? i_phys_addr_reg : 32'h0000_0000, p_ip, "fetch address");
      chk(p_dq ? d_phys_addr_reg : 32'h0000_0000, p_dp, "data address");
      chk(d_wdata_reg, p_wd, "write data");
      {p_fl, p_ip, p_dp, p_iq, p_dq, p_wd} = {e_fl, e_ip, e_dp, r[25], r[22], wd};
    end
    // second reset with fills aimed at disabled caches
    @(posedge sys_clk);
    rst_n <= 1'b0;
    ctrl_word <= 32'h0000_4000;
    {i_req, d_req, i_fill_req, d_fill_req} <= 4'b0011;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk({i_route_reg, d_route_reg, i_victim_reg, d_victim_reg}, 32'h0000_0000, "victim moved");
    @(posedge sys_clk);
    ctrl_word <= 32'h0000_5004; // round robin with both caches on
    repeat (8) @(posedge sys_clk);
    {i_fill_req, d_fill_req} <= 2'b00;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(wr_count, n_tw, "tight write count");
    // eight round robin fills from zero leave way three chosen last
    chk({i_victim_reg, d_victim_reg}, 32'h0000_000F, "round robin victim");
    @(posedge sys_clk);
    ctrl_word <= 32'h0000_1004; // random policy with both caches on
    @(posedge sys_clk);
    {i_fill_req, d_fill_req} <= 2'b11;
    #1;
    v = lf[1:0];
    @(posedge sys_clk);
    {i_fill_req, d_fill_req} <= 2'b00;
    #1;
    chk({i_victim_reg, d_victim_reg}, {v, v}, "random victim");
    complete_run();
  end
endmodule

`default_nettype wire
